/* shared/dram_ctrl_cfg.svh */
// Timing counts for the asynchronous DRAM controller.
`ifndef DRAM_CTRL_CFG_SVH
`define DRAM_CTRL_CFG_SVH
`define CLK_PERIOD_NS      10
`define REFRESH_WINDOW_MS  16
`define REFRESH_ROWS       1024
`define POWERUP_PAUSE_US   200
`define INIT_CYCLES        8
`define ROW_LOW_NS         60
`define PRECHARGE_NS       40
`define COL_LOW_NS         20
`define COL_HIGH_NS        10
`define ROW_LOW_CYC        ((`ROW_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_CYC      ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_LOW_CYC        ((`COL_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_HIGH_CYC       ((`COL_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_CYC (`REFRESH_WINDOW_MS * 1000000 / `CLK_PERIOD_NS / `REFRESH_ROWS)
`define POWERUP_CYC        (`POWERUP_PAUSE_US * 1000 / `CLK_PERIOD_NS)
`endif

/* shared/dram_ctrl_pkg.sv */
// Types shared by the asynchronous DRAM controller files.
package dram_ctrl_pkg;
    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_RMW   = 2'b10
    } op_kind_t;

    typedef struct packed {
        op_kind_t    kind;
        logic [9:0]  row;
        logic [9:0]  col;
        logic [1:0]  lanes;
        logic [15:0] wdata;
        logic        keep_row;
    } req_t;

    typedef struct packed {
        logic        row_strobe_n;
        logic        low_byte_col_strobe_n;
        logic        high_byte_col_strobe_n;
        logic        write_enable_n;
        logic        output_enable_n;
        logic [9:0]  mux_address;
        logic [15:0] data_out;
        logic [1:0]  data_oe;
    } pins_t;

    typedef enum logic [10:0] {
        ST_PAUSE   = 11'b000_0000_0001,
        ST_INIT    = 11'b000_0000_0010,
        ST_IDLE    = 11'b000_0000_0100,
        ST_ROW     = 11'b000_0000_1000,
        ST_COL     = 11'b000_0001_0000,
        ST_MODIFY  = 11'b000_0010_0000,
        ST_PAGE    = 11'b000_0100_0000,
        ST_CLOSE   = 11'b000_1000_0000,
        ST_PRECHG  = 11'b001_0000_0000,
        ST_REF_CAS = 11'b010_0000_0000,
        ST_REF_ROW = 11'b100_0000_0000
    } state_t;
endpackage

/* rtl/refresh_timer.sv */
// Refresh interval timer that raises a pending flag once per row period.
`timescale 1ns/1ps
`include "dram_ctrl_cfg.svh"
module refresh_timer
    import dram_ctrl_pkg::*;
#(
    parameter int PERIOD_CYC = `REFRESH_PERIOD_CYC
)(
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic enable,
    input  wire logic served,
    output logic      pending
);
    initial
    begin
        if (PERIOD_CYC < 2 || PERIOD_CYC > 65535)
            $error("refresh period out of range");
    end

    typedef struct packed {
        logic [15:0] count;
        logic        pending;
    } tmr_t;

    tmr_t cur;
    tmr_t next_cur;

    always_comb
    begin
        next_cur = cur;
        if (enable)
        begin
            if (cur.count == 16'(PERIOD_CYC - 1))
                next_cur.count = 16'h0000;
            else
                next_cur.count = cur.count + 16'h0001;
        end
        if (served)
            next_cur.pending = 1'b0;
        // A tick in the serving cycle wins over the clear.
        if (enable && cur.count == 16'(PERIOD_CYC - 1))
            next_cur.pending = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign pending = cur.pending;

    AST_TICK_SETS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        enable && cur.count == 16'(PERIOD_CYC - 1) |=> pending)
        else $error("refresh tick did not raise pending");
endmodule

/* rtl/dram_host_ctrl.sv */
// Controller that drives an asynchronous x16 DRAM with extended-output page mode.
`timescale 1ns/1ps
`include "dram_ctrl_cfg.svh"
module dram_host_ctrl
    import dram_ctrl_pkg::*;
#(
    parameter int POWERUP_CYC = `POWERUP_CYC,
    parameter int REFRESH_CYC = `REFRESH_PERIOD_CYC
)(
    input  wire logic   sys_clk,
    input  wire logic   arst_n,
    input  wire logic   req_valid,
    output logic        req_ready,
    input  req_t        req,
    output logic        rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic        init_done,
    output pins_t       pins,
    input  wire logic [15:0] data_in
);
    initial
    begin
        if (POWERUP_CYC < 1 || POWERUP_CYC > 1048575)
            $error("power-up count out of range");
    end

    typedef struct packed {
        state_t      st;
        logic [19:0] cnt;
        logic [3:0]  inits;
        pins_t       p;
        req_t        r;
        logic        rsp_valid;
        logic [15:0] rdata;
        logic        done;
    } ctl_t;

    ctl_t cur;
    ctl_t next_cur;
    logic [15:0] din_meta;
    logic [15:0] din_sync;
    logic        ref_pending;
    logic        ref_served;

    function automatic logic [15:0] lane_mask(input logic [1:0] lanes);
        lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
    endfunction

    refresh_timer #(
        .PERIOD_CYC (REFRESH_CYC)
    ) u_timer (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .enable  (cur.done),
        .served  (ref_served),
        .pending (ref_pending)
    );

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            din_meta <= 16'h0000;
            din_sync <= 16'h0000;
        end
        else
        begin
            din_meta <= data_in;
            din_sync <= din_meta;
        end
    end

    assign ref_served = cur.st == ST_REF_CAS && next_cur.st == ST_REF_ROW;
    // In page state only a same-row hit at the end of the strobe-high gap is taken; anything else must wait.
    assign req_ready  = cur.done && !ref_pending &&
                        (cur.st == ST_IDLE ||
                         (cur.st == ST_PAGE && cur.cnt == 20'h0_0000 && cur.r.keep_row && req.row == cur.r.row));

    always_comb
    begin
        next_cur = cur;
        next_cur.rsp_valid = 1'b0;
        if (cur.cnt != 20'h0_0000)
            next_cur.cnt = cur.cnt - 20'h0_0001;
        case (cur.st)
            ST_PAUSE:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    next_cur.st = ST_INIT;
                    next_cur.p.row_strobe_n = 1'b0;
                    next_cur.cnt = 20'(`ROW_LOW_CYC);
                end
            end
            ST_INIT:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    if (!cur.p.row_strobe_n)
                    begin
                        next_cur.p.row_strobe_n = 1'b1;
                        next_cur.cnt = 20'(`PRECHARGE_CYC);
                        next_cur.inits = cur.inits + 4'h1;
                    end
                    else if (cur.inits == 4'(`INIT_CYCLES))
                    begin
                        next_cur.st = ST_IDLE;
                        next_cur.done = 1'b1;
                    end
                    else
                    begin
                        next_cur.p.row_strobe_n = 1'b0;
                        next_cur.p.mux_address = 10'(cur.inits);
                        next_cur.cnt = 20'(`ROW_LOW_CYC);
                    end
                end
            end
            ST_IDLE:
            begin
                next_cur.p.data_oe = 2'b00;
                if (ref_pending)
                begin
                    next_cur.st = ST_REF_CAS;
                    next_cur.p.low_byte_col_strobe_n = 1'b0;
                    next_cur.p.high_byte_col_strobe_n = 1'b0;
                    next_cur.cnt = 20'(`COL_LOW_CYC);
                end
                else if (req_valid)
                begin
                    next_cur.r = req;
                    next_cur.st = ST_ROW;
                    next_cur.p.mux_address = req.row;
                    next_cur.p.row_strobe_n = 1'b0;
                    next_cur.cnt = 20'(`COL_LOW_CYC);
                end
            end
            ST_ROW:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    next_cur.st = ST_COL;
                    next_cur.p.mux_address = cur.r.col;
                    next_cur.p.low_byte_col_strobe_n = !cur.r.lanes[0];
                    next_cur.p.high_byte_col_strobe_n = !cur.r.lanes[1];
                    next_cur.p.write_enable_n = cur.r.kind != OP_WRITE;
                    next_cur.p.output_enable_n = cur.r.kind == OP_WRITE;
                    next_cur.p.data_out = cur.r.wdata;
                    next_cur.p.data_oe = cur.r.kind == OP_WRITE ? cur.r.lanes : 2'b00;
                    next_cur.cnt = 20'(`COL_LOW_CYC);
                end
            end
            ST_COL:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    if (cur.r.kind != OP_WRITE)
                        next_cur.rdata = din_sync & lane_mask(cur.r.lanes);
                    if (cur.r.kind == OP_RMW)
                    begin
                        next_cur.st = ST_MODIFY;
                        next_cur.p.output_enable_n = 1'b1;
                        next_cur.p.write_enable_n = 1'b0;
                        next_cur.p.data_out = cur.r.wdata;
                        next_cur.p.data_oe = cur.r.lanes;
                        next_cur.cnt = 20'(`COL_LOW_CYC);
                    end
                    else
                    begin
                        next_cur.st = ST_PAGE;
                        next_cur.rsp_valid = 1'b1;
                        next_cur.p.low_byte_col_strobe_n = 1'b1;
                        next_cur.p.high_byte_col_strobe_n = 1'b1;
                        next_cur.cnt = 20'(`COL_HIGH_CYC);
                    end
                end
            end
            ST_MODIFY:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    next_cur.st = ST_PAGE;
                    next_cur.rsp_valid = 1'b1;
                    next_cur.p.low_byte_col_strobe_n = 1'b1;
                    next_cur.p.high_byte_col_strobe_n = 1'b1;
                    next_cur.cnt = 20'(`COL_HIGH_CYC);
                end
            end
            ST_PAGE:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    next_cur.p.data_oe = 2'b00;
                    if (cur.r.keep_row && req_valid && !ref_pending && req.row == cur.r.row)
                    begin
                        next_cur.r = req;
                        next_cur.st = ST_ROW;
                        next_cur.cnt = 20'h0_0000;
                    end
                    else if (!cur.r.keep_row || ref_pending || req_valid)
                    begin
                        next_cur.st = ST_CLOSE;
                    end
                end
            end
            ST_CLOSE:
            begin
                next_cur.p.row_strobe_n = 1'b1;
                next_cur.p.write_enable_n = 1'b1;
                next_cur.p.output_enable_n = 1'b1;
                next_cur.st = ST_PRECHG;
                next_cur.cnt = 20'(`PRECHARGE_CYC);
            end
            ST_PRECHG:
            begin
                if (cur.cnt == 20'h0_0000)
                    next_cur.st = ST_IDLE;
            end
            ST_REF_CAS:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    next_cur.st = ST_REF_ROW;
                    next_cur.p.row_strobe_n = 1'b0;
                    next_cur.cnt = 20'(`ROW_LOW_CYC);
                end
            end
            ST_REF_ROW:
            begin
                if (cur.cnt == 20'h0_0000)
                begin
                    next_cur.p.low_byte_col_strobe_n = 1'b1;
                    next_cur.p.high_byte_col_strobe_n = 1'b1;
                    next_cur.st = ST_CLOSE;
                end
            end
            default:
                next_cur.st = ST_IDLE;
        endcase
        if (next_cur.st == ST_IDLE || next_cur.st == ST_PRECHG)
            next_cur.p.data_oe = 2'b00;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur <= '0;
            cur.st <= ST_PAUSE;
            cur.cnt <= 20'(POWERUP_CYC);
            cur.p.row_strobe_n <= 1'b1;
            cur.p.low_byte_col_strobe_n <= 1'b1;
            cur.p.high_byte_col_strobe_n <= 1'b1;
            cur.p.write_enable_n <= 1'b1;
            cur.p.output_enable_n <= 1'b1;
        end
        else
            cur <= next_cur;
    end

    assign pins      = cur.p;
    assign rsp_valid = cur.rsp_valid;
    assign rsp_rdata = cur.rdata;
    assign init_done = cur.done;

    AST_CBR_ORDER: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(pins.row_strobe_n) && cur.st == ST_REF_ROW |->
        !pins.low_byte_col_strobe_n && !pins.high_byte_col_strobe_n && pins.data_oe == 2'b00)
        else $error("strobe-first refresh without column strobe low");
    AST_STANDBY_QUIET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pins.row_strobe_n && pins.low_byte_col_strobe_n && pins.high_byte_col_strobe_n |-> pins.data_oe == 2'b00)
        else $error("data driven in standby");
    AST_NO_ACCESS_BEFORE_INIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !init_done |-> pins.low_byte_col_strobe_n && pins.high_byte_col_strobe_n && !req_ready)
        else $error("access before initialization");
    AST_WRITE_LANES: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !pins.write_enable_n && !pins.row_strobe_n |->
        pins.data_oe == ~{pins.high_byte_col_strobe_n, pins.low_byte_col_strobe_n} || cur.st == ST_PAGE)
        else $error("write lanes differ from column strobes");
    AST_READ_UNDRIVEN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !pins.output_enable_n && pins.write_enable_n |-> pins.data_oe == 2'b00)
        else $error("host drives data during read");
    AST_RMW_SEQ: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cur.st == ST_COL && cur.r.kind == OP_RMW && cur.cnt == 20'h0_0000 |=>
        pins.output_enable_n && !pins.write_enable_n && !pins.row_strobe_n)
        else $error("read-modify-write did not turn to write");
    AST_CLOSE_PRECHG: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(pins.row_strobe_n) |-> pins.row_strobe_n [*3])
        else $error("precharge too short");
    AST_RSP_ONCE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    COV_PAGE: cover property (@(posedge sys_clk) disable iff (!arst_n)
        cur.st == ST_PAGE ##1 cur.st == ST_ROW);
    COV_REFRESH: cover property (@(posedge sys_clk) disable iff (!arst_n) cur.st == ST_REF_ROW);
    COV_RMW: cover property (@(posedge sys_clk) disable iff (!arst_n) cur.st == ST_MODIFY);
endmodule

/* bench/dram_model.sv */
// Behavioural x16 page-mode DRAM that answers the controller's pins.
`timescale 1ns/1ps
module dram_model
    import dram_ctrl_pkg::*;
(
    input  wire logic   noise_clk,
    input  pins_t       pins,
    output logic [15:0] data_lines,
    output int          row_opens,
    output int          cbr_count,
    output int          errors
);
    logic [15:0] mem [int];
    logic [9:0]  row;
    logic [8:0]  ref_row;
    logic [15:0] rd_word;
    logic [1:0]  rd_lane;
    logic [1:0]  cas_low;
    logic [1:0]  dev_oe;
    logic        strobe_first_refresh;
    logic        flip;
    int          idx;

    assign cas_low = ~{pins.high_byte_col_strobe_n, pins.low_byte_col_strobe_n};

    initial
    begin
        row_opens = 0;
        cbr_count = 0;
        errors = 0;
        ref_row = 9'h000;
        rd_lane = 2'h0;
        strobe_first_refresh = 1'b0;
        flip = 1'b0;
    end

    task automatic store();
        if (!mem.exists(idx))
            mem[idx] = 16'h0000;
        for (int i = 0; i < 2; i++)
        begin
            if (cas_low[i])
            begin
                if (!pins.data_oe[i])
                    errors++;
                mem[idx][8*i +: 8] = data_lines[8*i +: 8];
            end
        end
        rd_lane = 2'h0;
    endtask

    always @(negedge pins.row_strobe_n)
    begin
        strobe_first_refresh = (cas_low != 2'h0);
        if (strobe_first_refresh)
        begin
            ref_row = ref_row + 9'h001;
            cbr_count++;
        end
        else
        begin
            row = pins.mux_address;
            row_opens++;
        end
    end

    always @(posedge pins.row_strobe_n)
        rd_lane = 2'h0;

    always @(negedge pins.low_byte_col_strobe_n or negedge pins.high_byte_col_strobe_n)
    begin
        if (!pins.row_strobe_n && !strobe_first_refresh)
        begin
            if (row_opens < 9)
                errors++;
            idx = {row, pins.mux_address};
            rd_word = mem.exists(idx) ? mem[idx] : 16'h0000;
            #1;
            if (!pins.write_enable_n)
                store();
            else
                rd_lane = cas_low;
        end
    end

    always @(negedge pins.write_enable_n)
    begin
        if (!pins.row_strobe_n && !strobe_first_refresh && cas_low != 2'h0)
        begin
            #1;
            store();
        end
    end

    always @*
    begin
        dev_oe = rd_lane & {2{!pins.output_enable_n && pins.write_enable_n && !pins.row_strobe_n}};
        for (int i = 0; i < 2; i++)
            data_lines[8*i +: 8] = pins.data_oe[i] ? pins.data_out[8*i +: 8] :
                                   dev_oe[i] ? rd_word[8*i +: 8] : {8{flip}} ^ 8'h5A;
    end

    always @(posedge noise_clk)
    begin
        flip <= ~flip;
        if ((dev_oe & pins.data_oe) != 2'h0)
            errors++;
        if (strobe_first_refresh && !pins.row_strobe_n && pins.data_oe != 2'h0)
            errors++;
    end
endmodule

/* bench/tb_dram_host_ctrl.sv */
// Self-checking testbench for the DRAM controller against the DRAM model.
`timescale 1ns/1ps
module tb_dram_host_ctrl
    import dram_ctrl_pkg::*;
;
    logic        sys_clk;
    logic        arst_n;
    logic        req_valid;
    logic        req_ready;
    req_t        req;
    logic        rsp_valid;
    logic [15:0] rsp_rdata;
    logic        init_done;
    pins_t       pins;
    logic [15:0] data_lines;
    int          row_opens;
    int          cbr_count;
    int          errors;
    int          mismatches;
    int          checks_done;
    int          cycles;
    logic [15:0] rd;

    dram_host_ctrl #(.POWERUP_CYC(50), .REFRESH_CYC(400)) u_dram_host_ctrl (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .req_valid (req_valid),
        .req_ready (req_ready),
        .req       (req),
        .rsp_valid (rsp_valid),
        .rsp_rdata (rsp_rdata),
        .init_done (init_done),
        .pins      (pins),
        .data_in   (data_lines)
    );

    dram_model u_dram_model (
        .noise_clk  (sys_clk),
        .pins       (pins),
        .data_lines (data_lines),
        .row_opens  (row_opens),
        .cbr_count  (cbr_count),
        .errors     (errors)
    );

    task automatic summarize();
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (exp !== got)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic run_req(input op_kind_t kind, input logic [9:0] r, input logic [9:0] c, input logic [1:0] lanes,
                           input logic [15:0] wdata, input logic keep, output logic [15:0] rdata);
        int n;
        @(posedge sys_clk);
        req <= '{kind: kind, row: r, col: c, lanes: lanes, wdata: wdata, keep_row: keep};
        req_valid <= 1'b1;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 300);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (rsp_valid !== 1'b1 && n < 60);
        check("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
        rdata = rsp_rdata;
    endtask

    task automatic t_reset();
        repeat (6) @(negedge sys_clk);
        check("reset strobes", 16'h001F, {11'h000, pins.row_strobe_n, pins.low_byte_col_strobe_n,
              pins.high_byte_col_strobe_n, pins.write_enable_n, pins.output_enable_n});
        check("reset oe ready init", 16'h0000, {12'h000, pins.data_oe, req_ready, init_done});
        @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int n = 0; n < 500 && init_done !== 1'b1; n++)
            @(negedge sys_clk);
        check("init_done", 16'h0001, {15'h0000, init_done});
        check("init row cycles", 16'h0001, {15'h0000, row_opens >= 8});
    endtask

    task automatic t_word();
        run_req(OP_WRITE, 10'h005, 10'h007, 2'h3, 16'hA5C3, 1'b0, rd);
        run_req(OP_READ, 10'h005, 10'h007, 2'h3, 16'h0000, 1'b0, rd);
        check("word read", 16'hA5C3, rd);
    endtask

    task automatic t_bytes();
        run_req(OP_WRITE, 10'h009, 10'h3FF, 2'h3, 16'h1234, 1'b0, rd);
        run_req(OP_WRITE, 10'h009, 10'h3FF, 2'h1, 16'hFFAB, 1'b0, rd);
        run_req(OP_READ, 10'h009, 10'h3FF, 2'h1, 16'h0000, 1'b0, rd);
        check("low byte read", 16'h00AB, rd);
        run_req(OP_READ, 10'h009, 10'h3FF, 2'h2, 16'h0000, 1'b0, rd);
        check("high byte read", 16'h1200, rd);
        run_req(OP_WRITE, 10'h009, 10'h3FF, 2'h2, 16'hCD77, 1'b0, rd);
        run_req(OP_READ, 10'h009, 10'h3FF, 2'h3, 16'h0000, 1'b0, rd);
        check("merged word", 16'hCDAB, rd);
    endtask

    task automatic t_page();
        int c0;
        int r0;
        c0 = cbr_count;
        for (int n = 0; n < 600 && cbr_count == c0; n++)
            @(negedge sys_clk);
        r0 = row_opens;
        for (int i = 0; i < 3; i++)
            run_req(OP_WRITE, 10'h3FF, 10'(i * 511), 2'h3, 16'(16'h1100 * (i + 1)), 1'b1, rd);
        for (int i = 0; i < 3; i++)
        begin
            run_req(OP_READ, 10'h3FF, 10'(i * 511), 2'h3, 16'h0000, 1'(i < 2), rd);
            check("page read", 16'(16'h1100 * (i + 1)), rd);
        end
        check("page row opens", 16'h0001, 16'(row_opens - r0));
    endtask

    task automatic t_rmw();
        run_req(OP_RMW, 10'h005, 10'h007, 2'h3, 16'h0F0F, 1'b0, rd);
        check("rmw old word", 16'hA5C3, rd);
        run_req(OP_RMW, 10'h005, 10'h007, 2'h2, 16'hF000, 1'b0, rd);
        check("rmw old high", 16'h0F00, rd);
        run_req(OP_READ, 10'h005, 10'h007, 2'h3, 16'h0000, 1'b0, rd);
        check("rmw new word", 16'hF00F, rd);
    endtask

    task automatic t_refresh();
        int c0;
        c0 = cbr_count;
        repeat (2000) @(posedge sys_clk);
        check("refresh rate", 16'h0001, {15'h0000, cbr_count - c0 >= 4 && cbr_count - c0 <= 6});
        check("model errors", 16'h0000, 16'(errors));
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        t_reset();
        t_word();
        t_bytes();
        t_page();
        t_rmw();
        t_refresh();
        summarize();
    end
endmodule
